// ==== logic/sat_defines.svh ====
// Constants of the segmented address translation unit.
// Assumes inclusion by sat_pkg and by the design modules.
`ifndef SAT_DEFINES_SVH
`define SAT_DEFINES_SVH
// ----------------------------------------------------------------
// Register byte offsets (Avalon-MM slave)
// ----------------------------------------------------------------
`define SAT_REG_CTRL 8'h00
`define SAT_REG_STATUS 8'h04
`define SAT_REG_MASK 8'h08
`define SAT_REG_GLOB_BASE 8'h0c
`define SAT_REG_LOC_BASE 8'h10
`define SAT_REG_PRIV 8'h14
`define SAT_REG_ERR 8'h18
`define SAT_REG_LIN 8'h1c
// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define SAT_CTRL_PROT 0
`define SAT_EVT_W 2
`define SAT_EVT_DONE 0
`define SAT_EVT_FAULT 1
`define SAT_SEL_TI 2
`define SAT_SEL_IDX_LO 3
`define SAT_DESC_BASE_HI 31
`define SAT_DESC_TYPE_LO 32
`define SAT_DESC_TYPE_HI 35
`define SAT_DESC_CODE 35
`define SAT_DESC_DPL_LO 36
`define SAT_DESC_DPL_HI 37
`define SAT_DESC_PRESENT 38
`define SAT_DESC_USE_LO 40
`define SAT_DESC_USE_HI 47
`define SAT_DESC_SHIFT 3
`define SAT_REAL_SHIFT 4
`define SAT_RPL_MASK 16'hfffc
`define SAT_ERR_NONE 16'h0000
`define SAT_PRIV_RESET 2'h0
`endif

// ==== logic/sat_pkg.sv ====
// Types of the segmented address translation unit.
// Assumes sat_defines.svh on the include path.
`include "sat_defines.svh"
package sat_pkg;
	// Controller states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SEL = 5'h02,
		ST_FETCH = 5'h04,
		ST_CHECK = 5'h08,
		ST_RESP = 5'h10
	} sat_st_type;
	// Access kinds issued by the core
	typedef enum logic [2:0] {
		KIND_DATA = 3'h0,
		KIND_FETCH = 3'h1,
		KIND_STACK = 3'h2,
		KIND_LOAD_CODE = 3'h3,
		KIND_LOAD_STACK = 3'h4
	} sat_kind_type;
endpackage : sat_pkg

// ==== logic/sat_chk_if.sv ====
// Carrier between translation controller, decoder and checker.
// Assumes all three sit on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface sat_chk_if;
	import sat_pkg::*;
	logic [15:0] sel;
	logic [63:0] desc;
	sat_kind_type kind;
	logic [1:0] priv;
	logic [12:0] index;
	logic ti;
	logic [1:0] rpl;
	logic null_sel;
	logic [31:0] base;
	logic [3:0] seg_type;
	logic [1:0] dpl;
	logic present;
	logic [7:0] usage;
	logic allow;
	logic [15:0] err_code;
	modport ctl (output sel, desc, kind, priv,
		input index, ti, null_sel, base, dpl, allow, err_code);
	modport dec (input sel, desc,
		output index, ti, rpl, null_sel, base, seg_type, dpl,
		present, usage);
	modport chk (input kind, priv, sel, rpl, null_sel, seg_type,
		dpl, present, output allow, err_code);
endinterface : sat_chk_if
`default_nettype wire

// ==== logic/sat_sel_decode.sv ====
// Selector and descriptor field decoder, purely combinational.
// Assumes descriptor bytes arrive low byte at lowest address.
`timescale 1ns/1ps
`default_nettype none
`include "sat_defines.svh"
module sat_sel_decode
	import sat_pkg::*;
(
	sat_chk_if.dec c
);
	// Selector: index, table choice, requested level (see R03)
	assign c.index = c.sel[15:`SAT_SEL_IDX_LO];
	assign c.ti = c.sel[`SAT_SEL_TI];
	assign c.rpl = c.sel[1:0];
	// Index 0 of the global table carries no segment
	assign c.null_sel = (c.index == 13'h0000) & ~c.ti;
	// Descriptor fields, little-endian word (see R04) (see R15)
	assign c.base = c.desc[`SAT_DESC_BASE_HI:0];
	assign c.seg_type = c.desc[`SAT_DESC_TYPE_HI:`SAT_DESC_TYPE_LO];
	assign c.dpl = c.desc[`SAT_DESC_DPL_HI:`SAT_DESC_DPL_LO];
	assign c.present = c.desc[`SAT_DESC_PRESENT];
	assign c.usage = c.desc[`SAT_DESC_USE_HI:`SAT_DESC_USE_LO];
endmodule : sat_sel_decode
`default_nettype wire

// ==== logic/sat_priv_check.sv ====
// Privilege and type check of one looked-up segment.
// Assumes decoded fields stay stable during the check state.
`timescale 1ns/1ps
`default_nettype none
`include "sat_defines.svh"
module sat_priv_check
	import sat_pkg::*;
(
	sat_chk_if.chk c
);
	logic is_code;
	logic [1:0] eff;
	logic ok;
	// Type, presence and level test (see R07)
	always_comb begin
		is_code = c.seg_type[`SAT_DESC_CODE - `SAT_DESC_TYPE_LO];
		eff = (c.rpl > c.priv) ? c.rpl : c.priv;
		unique case (c.kind)
			KIND_FETCH, KIND_LOAD_CODE: begin
				ok = is_code & (c.dpl >= c.priv);
			end
			KIND_STACK, KIND_LOAD_STACK: begin
				ok = ~is_code & (c.dpl == c.priv) & (c.rpl == c.priv);
			end
			default: begin
				ok = ~is_code & (c.dpl >= eff);
			end
		endcase
		c.allow = ok & c.present & ~c.null_sel;
		// Null selector gives no accurate code (see R12)
		c.err_code = c.null_sel ? `SAT_ERR_NONE
			: (c.sel & `SAT_RPL_MASK);
	end
endmodule : sat_priv_check
`default_nettype wire

// ==== logic/sat_top.sv ====
// Segmented address translation and protection unit, top level.
// Assumes one core clock, a same-clock core request port, a
// same-clock descriptor read port and an Avalon-MM master.
//
// Operation
// R01: Memory is a flat run of bytes and every access gets one byte address.
// R02: The core gives a selector and an offset together with each request.
// R03: A selector splits into table index, table choice and requested level.
// R04: A descriptor yields base, rights, type and usage used in the check.
// R05: The linear address is the segment base plus the offset.
// R06: In protected operation every access goes through a table lookup.
// R07: An access is allowed only if reachable from the current level.
// R08: The current level is that of the code segment now executing.
// R09: Global lookups use the global table base register.
// R10: Local lookups use the local table register.
// R11: Fetches use the code segment and stack accesses the stack segment.
// R12: A fault without an accurate error code reports code zero.
// R13: After reset the unit runs in real-address operation.
// R14: Only software switches the unit into protected operation.
// R15: Multi-byte values are little-endian.
// R16: A failed check aborts with a protection fault and no address.
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sat_defines.svh"
module sat_top
	import sat_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] AV_ADDRESS,
	input wire logic AV_READ,
	input wire logic AV_WRITE,
	input wire logic [31:0] AV_WRITEDATA,
	output logic [31:0] AV_READDATA,
	output logic AV_WAITREQUEST,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic [2:0] REQ_KIND,
	input wire logic [15:0] REQ_SEL,
	input wire logic [31:0] REQ_OFFSET,
	output logic RSP_VALID,
	output logic [31:0] RSP_LIN_ADDR,
	output logic RSP_FAULT,
	output logic [15:0] RSP_ERR_CODE,
	output logic DESC_RD,
	output logic [31:0] DESC_ADDR,
	input wire logic DESC_WAIT,
	input wire logic [63:0] DESC_DATA,
	output logic IRQ
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		sat_st_type st;
		logic prot;
		logic [31:0] global_table_base_reg;
		logic [31:0] local_table_reg;
		logic [15:0] code_seg_sel;
		logic [15:0] stack_seg_sel;
		logic [1:0] current_privilege_level;
		logic [`SAT_EVT_W-1:0] sts;
		logic [`SAT_EVT_W-1:0] msk;
		sat_kind_type kind;
		logic [15:0] sel;
		logic [31:0] off;
		logic [63:0] desc;
		logic [31:0] daddr;
		logic [31:0] lin;
		logic flt;
		logic [15:0] err;
		logic [7:0] usage; // Usage field of the last granted segment, cleared to zero by a fault
		logic ack;
		logic [31:0] rdata;
	} sat_regs_type;

	sat_regs_type s_q;
	sat_regs_type s_d;
	sat_chk_if c ();
	logic bus_req;
	logic bus_take;
	logic [`SAT_EVT_W-1:0] evt_set;
	logic [`SAT_EVT_W-1:0] evt_clr;
	logic [31:0] real_addr;
	logic [31:0] tbl_base;
	logic [31:0] tbl_off;
	logic [31:0] code_real;
	logic [31:0] stack_real;
	sat_kind_type req_kind;

	// ----------------------------------------------------------------
	// Decoder and checker
	// ----------------------------------------------------------------
	// Both look at the captured selector and descriptor
	// Purely combinational; the check state gives them a full cycle
	assign c.sel = s_q.sel;
	assign c.desc = s_q.desc;
	assign c.kind = s_q.kind;
	assign c.priv = s_q.current_privilege_level;

	sat_sel_decode u_dec (
		.c(c.dec)
	);

	sat_priv_check u_chk (
		.c(c.chk)
	);

	// ----------------------------------------------------------------
	// Helper terms
	// ----------------------------------------------------------------
	// Real mode: selector times sixteen plus offset
	assign real_addr = (32'(REQ_SEL) << `SAT_REAL_SHIFT) + REQ_OFFSET;
	// Held code and stack selectors in real mode (see R11)
	assign code_real = (32'(s_q.code_seg_sel) << `SAT_REAL_SHIFT)
		+ REQ_OFFSET;
	assign stack_real = (32'(s_q.stack_seg_sel) << `SAT_REAL_SHIFT)
		+ REQ_OFFSET;
	// Table picked by the selector flag (see R09) (see R10)
	assign tbl_base = c.ti ? s_q.local_table_reg
		: s_q.global_table_base_reg;
	// Eight bytes per descriptor entry; no limit check, so an
	// index past the table end reads whatever lies there
	assign tbl_off = 32'(c.index) << `SAT_DESC_SHIFT;
	// Codes past the last kind fall to the data path of the checker
	assign req_kind = sat_kind_type'(REQ_KIND);
	// A bus cycle is taken on its second edge
	assign bus_req = AV_READ | AV_WRITE;
	assign bus_take = bus_req & s_q.ack;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		evt_set = '0;
		evt_clr = '0;

		// Bus: one wait cycle, read data loaded meanwhile.
		// The wait state lets the read mux settle into a flop,
		// at the cost of two cycles per access.
		s_d.ack = bus_req & ~s_q.ack;
		if (bus_req & ~s_q.ack) begin
			unique case (AV_ADDRESS)
				`SAT_REG_CTRL: begin
					s_d.rdata = 32'(s_q.prot);
				end
				`SAT_REG_STATUS: begin
					s_d.rdata = 32'(s_q.sts);
				end
				`SAT_REG_MASK: begin
					s_d.rdata = 32'(s_q.msk);
				end
				`SAT_REG_GLOB_BASE: begin
					s_d.rdata = s_q.global_table_base_reg;
				end
				`SAT_REG_LOC_BASE: begin
					s_d.rdata = s_q.local_table_reg;
				end
				`SAT_REG_PRIV: begin
					s_d.rdata = {s_q.code_seg_sel, 14'h0000,
						s_q.current_privilege_level};
				end
				`SAT_REG_ERR: begin
					// Usage byte on top, padding kept zero
					s_d.rdata = {s_q.usage, 7'h00, s_q.flt, s_q.err};
				end
				`SAT_REG_LIN: begin
					s_d.rdata = s_q.lin;
				end
				default: begin
					// Unmapped offsets read zero
					s_d.rdata = 32'h0000_0000;
				end
			endcase
		end

		// Register writes land on the accepting edge
		if (bus_take & AV_WRITE) begin
			unique case (AV_ADDRESS)
				`SAT_REG_CTRL: begin
					// Mode change only by software (see R14)
					s_d.prot = AV_WRITEDATA[`SAT_CTRL_PROT];
				end
				`SAT_REG_STATUS: begin
					evt_clr = AV_WRITEDATA[`SAT_EVT_W-1:0];
				end
				`SAT_REG_MASK: begin
					s_d.msk = AV_WRITEDATA[`SAT_EVT_W-1:0];
				end
				`SAT_REG_GLOB_BASE: begin
					s_d.global_table_base_reg = AV_WRITEDATA; // see R09
				end
				`SAT_REG_LOC_BASE: begin
					s_d.local_table_reg = AV_WRITEDATA; // see R10
				end
				default: begin
					// Read-only or unmapped: write dropped
					s_d.msk = s_q.msk;
				end
			endcase
		end

		// Translation controller
		unique case (s_q.st)
			ST_IDLE: begin
				// Selector and offset taken together (see R02)
				if (REQ_VALID) begin
					s_d.kind = req_kind;
					s_d.off = REQ_OFFSET;
					s_d.flt = 1'b0;
					s_d.err = `SAT_ERR_NONE;
					// Fetch and stack use their own segments (see R11)
					unique case (req_kind)
						KIND_FETCH: begin
							s_d.sel = s_q.code_seg_sel;
						end
						KIND_STACK: begin
							s_d.sel = s_q.stack_seg_sel;
						end
						default: begin
							s_d.sel = REQ_SEL;
						end
					endcase
					if (s_q.prot) begin
						// No path around the tables (see R06)
						s_d.st = ST_SEL;
					end else begin
						// Real-address translation (see R13)
						unique case (req_kind)
							KIND_FETCH: begin
								s_d.lin = code_real;
							end
							KIND_STACK: begin
								s_d.lin = stack_real;
							end
							default: begin
								s_d.lin = real_addr;
							end
						endcase
						if (req_kind == KIND_LOAD_CODE) begin
							s_d.code_seg_sel = REQ_SEL;
						end
						if (req_kind == KIND_LOAD_STACK) begin
							s_d.stack_seg_sel = REQ_SEL;
						end
						s_d.st = ST_RESP;
					end
				end
			end
			ST_SEL: begin
				// Entry address from index and table base
				s_d.daddr = tbl_base + tbl_off;
				// A null selector skips the memory read; the check sees
				// a stale descriptor but refuses on the null flag alone
				s_d.st = c.null_sel ? ST_CHECK : ST_FETCH;
			end
			ST_FETCH: begin
				// The port may stall for any number of cycles
				// Whole descriptor word, low byte first (see R15)
				if (!DESC_WAIT) begin
					s_d.desc = DESC_DATA;
					s_d.st = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (c.allow) begin
					// One byte address from base plus offset (see R05)
					s_d.lin = c.base + s_q.off; // see R01
					s_d.usage = c.usage; // see R04
					if (s_q.kind == KIND_LOAD_CODE) begin
						// Level follows the new code segment (see R08)
						s_d.code_seg_sel = s_q.sel;
						s_d.current_privilege_level = c.dpl;
					end
					if (s_q.kind == KIND_LOAD_STACK) begin
						s_d.stack_seg_sel = s_q.sel;
					end
				end else begin
					// Abort: fault, no address (see R16)
					s_d.flt = 1'b1;
					s_d.lin = 32'h0000_0000;
					s_d.usage = 8'h00;
					s_d.err = c.err_code; // see R12
				end
				s_d.st = ST_RESP;
			end
			ST_RESP: begin
				// Response shown for this one cycle
				// The core must take it now; nothing holds it
				evt_set[`SAT_EVT_DONE] = ~s_q.flt;
				evt_set[`SAT_EVT_FAULT] = s_q.flt; // see R16
				s_d.st = ST_IDLE;
			end
			default: begin
				// Illegal one-hot code: recover to idle
				s_d.st = ST_IDLE;
			end
		endcase

		// Sticky events: a new event beats its clear,
		// so an event in the clearing cycle is never lost
		s_d.sts = (s_q.sts & ~evt_clr) | evt_set;
		// Real mode always runs at the top level, so a code
		// segment load there leaves the level at zero
		if (!s_q.prot) begin
			s_d.current_privilege_level = `SAT_PRIV_RESET;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Reset lands in real-address mode, idle (see R13)
	// Only constants under reset; the struct clears as one
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.kind <= KIND_DATA;
			s_q.current_privilege_level <= `SAT_PRIV_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Handshakes from state, data from flops
	// Ready is the idle state alone: the core waits, no skid buffer
	assign AV_WAITREQUEST = bus_req & ~s_q.ack;
	assign AV_READDATA = s_q.rdata;
	assign REQ_READY = (s_q.st == ST_IDLE);
	assign RSP_VALID = (s_q.st == ST_RESP);
	assign RSP_LIN_ADDR = s_q.lin;
	assign RSP_FAULT = s_q.flt;
	assign RSP_ERR_CODE = s_q.err;
	assign DESC_RD = (s_q.st == ST_FETCH);
	assign DESC_ADDR = s_q.daddr;
	// Level interrupt while any unmasked event is pending
	assign IRQ = |(s_q.sts & s_q.msk);
endmodule : sat_top
`default_nettype wire

// ==== tb/sat_desc_mem.sv ====
// Descriptor memory model on the far side of the descriptor port.
// Assumes the bench fills mem and picks the stall count per request.
`timescale 1ns/1ps
`default_nettype none
module sat_desc_mem (
	input wire logic clk,
	input wire logic desc_rd,
	input wire logic [31:0] desc_addr,
	input wire logic [1:0] stall,
	output logic desc_wait,
	output logic [63:0] desc_data
);
	logic [63:0] mem [128];
	logic [1:0] cnt_q;
	logic [63:0] junk_q = 64'h0123456789abcdef;
	// Junk moves every cycle so stale data never looks valid
	always_ff @(posedge clk) begin
		junk_q <= {junk_q[62:0], ~junk_q[63]};
		cnt_q <= (desc_rd && desc_wait) ? cnt_q + 2'h1 : 2'h0;
	end
	// Slow or prompt answer, word low byte at lowest address
	assign desc_wait = desc_rd && (cnt_q < stall);
	assign desc_data = (desc_rd && !desc_wait) ? mem[desc_addr[9:3]] : junk_q;
endmodule : sat_desc_mem
`default_nettype wire

// ==== tb/sat_top_monitor.sv ====
// Port-level assertions of the translation unit.
// Assumes it is bound into sat_top by name.
`timescale 1ns/1ps
`default_nettype none
module sat_top_monitor
	import sat_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] AV_ADDRESS,
	input wire logic AV_READ,
	input wire logic AV_WRITE,
	input wire logic [31:0] AV_WRITEDATA,
	input wire logic AV_WAITREQUEST,
	input wire logic REQ_VALID,
	input wire logic REQ_READY,
	input wire logic [2:0] REQ_KIND,
	input wire logic [15:0] REQ_SEL,
	input wire logic [31:0] REQ_OFFSET,
	input wire logic RSP_VALID,
	input wire logic [31:0] RSP_LIN_ADDR,
	input wire logic RSP_FAULT,
	input wire logic [15:0] RSP_ERR_CODE,
	input wire logic DESC_RD,
	input wire logic [31:0] DESC_ADDR,
	input wire logic DESC_WAIT
);
	logic prot_q;
	logic [31:0] glob_q;
	logic [31:0] loc_q;
	logic [15:0] sel_q;
	logic [2:0] kind_q;
	wire logic take = REQ_VALID && REQ_READY;
	wire logic wr_ok = AV_WRITE && !AV_WAITREQUEST;
	// Shadow of mode, table bases and the last taken selector
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			prot_q <= 1'b0;
			glob_q <= 32'h0;
			loc_q <= 32'h0;
			sel_q <= 16'h0;
			kind_q <= 3'h0;
		end else begin
			if (wr_ok && AV_ADDRESS == 8'h00) prot_q <= AV_WRITEDATA[0];
			if (wr_ok && AV_ADDRESS == 8'h0c) glob_q <= AV_WRITEDATA;
			if (wr_ok && AV_ADDRESS == 8'h10) loc_q <= AV_WRITEDATA;
			if (take) sel_q <= REQ_SEL;
			if (take) kind_q <= REQ_KIND;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	property p_fault_nolin;
		RSP_VALID && RSP_FAULT |-> RSP_LIN_ADDR == 32'h0;
	endproperty
	a_fault_nolin: assert property (p_fault_nolin)
		else $error("address given on a fault");
	property p_err_clean;
		RSP_VALID && RSP_FAULT |-> RSP_ERR_CODE[1:0] == 2'h0;
	endproperty
	a_err_clean: assert property (p_err_clean)
		else $error("error code low bits set");
	property p_real_lin;
		take && !prot_q && REQ_KIND == 3'h0 |=> RSP_VALID &&
			RSP_LIN_ADDR == {12'h0, $past(REQ_SEL), 4'h0} + $past(REQ_OFFSET);
	endproperty
	a_real_lin: assert property (p_real_lin)
		else $error("real mode address wrong");
	property p_real_nodesc;
		!prot_q |-> !DESC_RD;
	endproperty
	a_real_nodesc: assert property (p_real_nodesc)
		else $error("table read in real mode");
	property p_prot_lookup;
		take && prot_q && REQ_KIND == 3'h0 && REQ_SEL[15:2] != 14'h0 |-> ##2 DESC_RD;
	endproperty
	a_prot_lookup: assert property (p_prot_lookup)
		else $error("no table lookup");
	property p_tbl_addr;
		$rose(DESC_RD) && kind_q != 3'h1 && kind_q != 3'h2 |->
			DESC_ADDR == (sel_q[2] ? loc_q : glob_q) + {16'h0, sel_q[15:3], 3'h0};
	endproperty
	a_tbl_addr: assert property (p_tbl_addr)
		else $error("descriptor address wrong");
	property p_desc_hold;
		DESC_RD && DESC_WAIT |=> DESC_RD && $stable(DESC_ADDR);
	endproperty
	a_desc_hold: assert property (p_desc_hold)
		else $error("descriptor read dropped");
	property p_av_wait;
		$rose(AV_READ || AV_WRITE) |-> AV_WAITREQUEST ##1 !AV_WAITREQUEST;
	endproperty
	a_av_wait: assert property (p_av_wait)
		else $error("register wait not one cycle");
	c_fault: cover property (RSP_VALID && RSP_FAULT);
	c_stall: cover property (DESC_RD && DESC_WAIT);
	c_real: cover property (take && !prot_q);
endmodule : sat_top_monitor
`default_nettype wire

// ==== tb/sat_top_bench.sv ====
// Self-checking bench of the translation unit.
// Assumes sat_top, sat_desc_mem and sat_top_monitor are compiled.
`timescale 1ns/1ps
`default_nettype none
module sat_top_bench;
	import sat_pkg::*;
	typedef struct {logic [31:0] lin; logic f; logic [15:0] e; bit cl;} sat_exp_type;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic [7:0] av_a = 8'h0;
	logic av_rd = 1'b0;
	logic av_wr = 1'b0;
	logic [31:0] av_wd = 32'h0;
	logic [31:0] av_q;
	logic av_wait;
	logic rq_v = 1'b0;
	logic rq_rdy;
	logic [2:0] rq_k = 3'h0;
	logic [15:0] rq_s = 16'h0;
	logic [31:0] rq_o = 32'h0;
	logic rsp_v;
	logic [31:0] rsp_lin;
	logic rsp_f;
	logic [15:0] rsp_e;
	logic d_rd;
	logic [31:0] d_addr;
	logic d_wait;
	logic [63:0] d_data;
	logic irq;
	logic [1:0] stall = 2'h0;
	logic [31:0] d;
	logic [31:0] o;
	logic [15:0] sr;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	sat_exp_type q[$];
	sat_exp_type e;
	sat_top i_dut (.CLK(CLK), .RST(RST), .AV_ADDRESS(av_a), .AV_READ(av_rd),
		.AV_WRITE(av_wr), .AV_WRITEDATA(av_wd), .AV_READDATA(av_q),
		.AV_WAITREQUEST(av_wait), .REQ_VALID(rq_v), .REQ_READY(rq_rdy),
		.REQ_KIND(rq_k), .REQ_SEL(rq_s), .REQ_OFFSET(rq_o), .RSP_VALID(rsp_v),
		.RSP_LIN_ADDR(rsp_lin), .RSP_FAULT(rsp_f), .RSP_ERR_CODE(rsp_e),
		.DESC_RD(d_rd), .DESC_ADDR(d_addr), .DESC_WAIT(d_wait),
		.DESC_DATA(d_data), .IRQ(irq));
	sat_desc_mem i_mem (.clk(CLK), .desc_rd(d_rd), .desc_addr(d_addr),
		.stall(stall), .desc_wait(d_wait), .desc_data(d_data));
	initial begin
		forever #12.5 CLK = ~CLK;
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	// Avalon access; request held until waitrequest seen low
	task automatic av(input bit wr, input logic [7:0] a, input logic [31:0] wd);
		logic w;
		@(posedge CLK);
		av_rd <= !wr;
		av_wr <= wr;
		av_a <= a;
		av_wd <= wd;
		do begin
			@(posedge CLK);
			w = av_wait;
			d = av_q;
		end while (w !== 1'b0);
		av_rd <= 1'b0;
		av_wr <= 1'b0;
	endtask : av
	// Core request with its expected answer noted first
	task automatic rq(input logic [2:0] k, input logic [15:0] s, input logic [31:0] of,
		lin, input logic f, input logic [15:0] ec, input bit cl);
		logic r;
		int n;
		q.push_back('{lin, f, ec, cl});
		@(posedge CLK);
		stall <= 2'($urandom_range(3));
		rq_v <= 1'b1;
		rq_k <= k;
		rq_s <= s;
		rq_o <= of;
		do begin
			@(posedge CLK);
			r = rq_rdy;
		end while (r !== 1'b1);
		rq_v <= 1'b0;
		n = 0;
		while (q.size() != 0 && n < 60) begin
			@(posedge CLK);
			n++;
		end
	endtask : rq
	function automatic logic [63:0] dsc(input logic [31:0] b, input logic [3:0] t,
		input logic [1:0] l, input logic p);
		return {24'h0, 1'b0, p, l, t, b};
	endfunction : dsc
	// Response watcher compares against the oldest note
	always @(negedge CLK) begin
		if (RST === 1'b0 && rsp_v === 1'b1 && q.size() == 0) begin
			chk("spare rsp", 32'h1, 32'h0);
		end else if (RST === 1'b0 && rsp_v === 1'b1) begin
			e = q.pop_front();
			chk("fault", 32'(rsp_f), 32'(e.f));
			chk("err", 32'(rsp_e), 32'(e.e));
			if (e.cl) chk("lin", rsp_lin, e.lin);
		end
	end
	// Hang guard
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(64896));
		repeat (12) @(posedge CLK);
		RST <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			av(0, (i == 8) ? 8'h40 : 8'(i * 4), 32'h0);
			chk("reg", d, 32'h0);
		end
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			sr = 16'($urandom());
			o = $urandom();
			rq(3'h0, sr, o, {12'h0, sr, 4'h0} + o, 0, 0, 1);
		end
		rq(3'h3, 16'h1234, 0, 0, 0, 0, 0);
		av(0, 8'h14, 0);
		chk("priv", d, 32'h12340000);
		rq(3'h1, 16'h0, o, 32'h00012340 + o, 0, 0, 1);
		$display("test real mode done");
		i_mem.mem[33] = dsc(32'h10000000, 4'h2, 2'h0, 1);
		i_mem.mem[35] = dsc(32'h20000000, 4'h2, 2'h0, 0);
		i_mem.mem[36] = dsc(32'h40000000, 4'ha, 2'h3, 1);
		i_mem.mem[65] = dsc(32'h30000000, 4'h2, 2'h3, 1);
		i_mem.mem[66] = dsc(32'h50000000, 4'h2, 2'h3, 1);
		av(1, 8'h0c, 32'h100);
		av(1, 8'h10, 32'h200);
		av(1, 8'h00, 32'h1);
		o = $urandom();
		rq(3'h0, 16'h0008, o, 32'h10000000 + o, 0, 0, 1);
		rq(3'h0, 16'h000f, o, 32'h30000000 + o, 0, 0, 1);
		rq(3'h0, 16'h000b, o, 0, 1, 16'h0008, 1);
		rq(3'h0, 16'h0000, o, 0, 1, 16'h0000, 1);
		rq(3'h0, 16'h0018, o, 0, 1, 16'h0018, 1);
		rq(3'h3, 16'h0023, 0, 0, 0, 0, 0);
		av(0, 8'h14, 0);
		chk("priv", d, 32'h00230003);
		rq(3'h1, 16'h0, o, 32'h40000000 + o, 0, 0, 1);
		rq(3'h0, 16'h000b, o, 0, 1, 16'h0008, 1);
		av(0, 8'h18, 0);
		chk("errreg", d, 32'h00010008);
		rq(3'h4, 16'h0017, 0, 0, 0, 0, 0);
		rq(3'h2, 16'h0, o, 32'h50000000 + o, 0, 0, 1);
		av(0, 8'h1c, 0);
		chk("linreg", d, 32'h50000000 + o);
		$display("test protected done");
		av(1, 8'h08, 32'h2);
		av(0, 8'h04, 0);
		chk("status", d, 32'h3);
		chk("irq", 32'(irq), 32'h1);
		av(1, 8'h04, 32'h2);
		av(1, 8'h40, 32'hffffffff);
		av(0, 8'h04, 0);
		chk("status", d, 32'h1);
		chk("irq", 32'(irq), 32'h0);
		av(0, 8'h40, 0);
		chk("unmapped", d, 32'h0);
		chk("left", 32'(q.size()), 32'h0);
		$display("test interrupt done");
		end_of_test();
	end
endmodule : sat_top_bench
bind sat_top sat_top_monitor i_mon (.*);
`default_nettype wire
